// ===== xsr_pkg.sv
// Package with register map, field layout and carrier types of the transceiver register set.
package xsr_pkg;
  localparam logic [7:0] MODE_CTRL_OFS = 8'hD0;
  localparam logic [7:0] CFG_STATUS_OFS = 8'hD4;
  localparam logic [7:0] IRQ_ENABLE_OFS = 8'hD8;
  localparam logic [7:0] TX100_CTRL_OFS = 8'hDC;
  localparam int LONG_REACH_BIT = 11;
  localparam int SPEED_BIT = 9;
  localparam int DUPLEX_BIT = 8;
  localparam int PAUSE_BIT = 7;
  localparam int EVT_MSB = 6;
  localparam int NUM_EVT = 7;
  localparam int ERR_COUNT_OFF_BIT = 13;
  localparam int AN_DONE_MIRROR_BIT = 12;
  localparam int RX_VPP_BIT = 11;
  localparam int REMOTE_LOOP_BIT = 9;
  localparam int BASELINE_BIT = 8;
  localparam int NRZI_BIT = 7;
  localparam int TX_ISOLATE_BIT = 5;
  localparam int OP_STATE_LSB = 2;
  localparam int MLT3_BYPASS_BIT = 1;
  localparam int SCRAMBLER_BYPASS_BIT = 0;
  localparam logic [15:0] TX100_WR_MASK = 16'h2BA3;
  localparam logic [6:0] RX_ERR_FULL_COUNT = 7'h40;
  localparam logic [6:0] EVT_ENABLE_RST = 7'h00;
  localparam logic [15:0] ZERO16 = 16'h0000;

  // Event bit order matches the status and enable registers (bit 6 down to bit 0).
  typedef struct packed {
    logic autoneg_done;
    logic far_fault;
    logic link_down;
    logic autoneg_ack;
    logic parallel_detect_fault;
    logic autoneg_page;
    logic rx_error_full;
  } xsr_evt_type;

  // Resolved link state reported by the transceiver core.
  typedef struct packed {
    logic speed_100;
    logic full_duplex;
    logic pause_on;
    logic [2:0] op_state;
  } xsr_link_type;

  // Static controls that steer the transceiver datapath.
  typedef struct packed {
    logic long_reach_squelch;
    logic rx_vpp_high;
    logic remote_loop_en;
    logic baseline_restore_en;
    logic line_inversion_code_en;
    logic tx_isolate;
    logic three_level_code_bypass;
    logic scrambler_bypass;
  } xsr_ctrl_type;

  typedef struct packed {
    logic [15:0] rdata;
    logic irq;
    logic err_count_run;
    xsr_ctrl_type ctrl;
    logic [6:0] evt;
    logic [6:0] irq_en;
    logic [6:0] err_cnt;
    logic link_up_prev;
    logic link_down_seen;
  } xsr_state_type;

  localparam xsr_ctrl_type CTRL_RST = '{default: 1'b0, baseline_restore_en: 1'b1, line_inversion_code_en: 1'b1};
endpackage

// ===== xsr_regs.sv
// Transceiver mode, status, interrupt enable and 100BASE-TX control registers.
//
// Summary of operation
// - Mode control bit 11 selects a lowered 10BASE-T squelch threshold for long cables.
// - Status bit 9 reports resolved speed: 0 is 10 Mb/s, 1 is 100 Mb/s.
// - Status bit 8 reports resolved duplex: 0 half, 1 full.
// - Status bit 7 reports whether pause flow control ended up enabled.
// - Bit 6 latches when auto-negotiation completes; a status read clears it.
// - Bit 5 latches on remote fault; a status read clears it.
// - Bit 4 latches on link down; clears on status read.
// - Bit 3 latches on received link code word; clears on status read.
// - Bit 2 latches on parallel detection fault; clears on status read.
// - Bit 1 latches on received auto-negotiation page; clears on status read.
// - Bit 0 latches once 64 receive errors are counted; clears on status read.
// - Enable register bits 6..0 gate the matching status events onto the interrupt.
// - Control bit 13 set stops the receive error counter; reset value runs it.
// - Control bit 12 mirrors the auto-negotiation complete indication.
// - Control bit 8 enables DC restoration; resets to 1.
// - Control bit 7 enables NRZ/NRZI conversion; resets to 1.
// - Control bit 5 isolates the transmitter; keep 0 for normal operation.
// - Control bits 4..2 report current operating mode code.
// - Control bit 1 bypasses the MLT3 encoder and decoder.
// - Control bit 0 disables scrambler and descrambler.
`timescale 1ns/1ps
module xsr_regs (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  input wire xsr_pkg::xsr_link_type i_link,
  input wire logic i_link_up,
  input wire logic i_autoneg_done,
  input wire logic i_far_fault,
  input wire logic i_autoneg_ack,
  input wire logic i_parallel_fault,
  input wire logic i_autoneg_page,
  input wire logic i_rx_error,
  output xsr_pkg::xsr_ctrl_type o_ctrl,
  output logic o_err_count_run,
  output logic o_irq
);

  xsr_pkg::xsr_state_type s_q;
  xsr_pkg::xsr_state_type s_d;
  xsr_pkg::xsr_evt_type evt_set;
  logic status_rd;
  logic err_full;
  logic err_hit;

  // ----------------------------------------------------------------
  // Event sources
  // ----------------------------------------------------------------
  // The counter saturates at the full mark, so the full condition holds until a read restarts the count.
  assign err_full = (s_q.err_cnt == xsr_pkg::RX_ERR_FULL_COUNT);
  assign status_rd = i_rd && (i_addr == xsr_pkg::CFG_STATUS_OFS);
  // The flag is raised by the error that reaches the mark, not by the full level.
  // A level source would win against the clearing read and keep the flag stuck.
  assign err_hit = s_q.err_count_run && i_rx_error && (s_q.err_cnt == xsr_pkg::RX_ERR_FULL_COUNT - 7'h01);

  always_comb begin
    evt_set.autoneg_done = i_autoneg_done;
    evt_set.far_fault = i_far_fault;
    evt_set.link_down = s_q.link_up_prev && !i_link_up;
    evt_set.autoneg_ack = i_autoneg_ack;
    evt_set.parallel_detect_fault = i_parallel_fault;
    evt_set.autoneg_page = i_autoneg_page;
    evt_set.rx_error_full = err_hit;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [15:0] ctrl_word;
    logic [6:0] evt_next;
    ctrl_word = xsr_pkg::ZERO16;
    evt_next = '0;
    s_d = s_q;
    s_d.rdata = xsr_pkg::ZERO16;
    s_d.link_up_prev = i_link_up;
    s_d.link_down_seen = evt_set.link_down;
    // Receive error counter; stops when disabled and rearms after the flag is read away.
    if (s_q.err_count_run && i_rx_error && !err_full) begin
      s_d.err_cnt = s_q.err_cnt + 7'h01;
    end
    if (status_rd && s_q.evt[0]) begin
      s_d.err_cnt = '0;
    end
    // Reads: the value shown is the one before this cycle's clear.
    if (i_rd) begin
      if (i_addr == xsr_pkg::MODE_CTRL_OFS) begin
        s_d.rdata[xsr_pkg::LONG_REACH_BIT] = s_q.ctrl.long_reach_squelch;
      end else if (i_addr == xsr_pkg::CFG_STATUS_OFS) begin
        s_d.rdata[xsr_pkg::SPEED_BIT] = i_link.speed_100;
        s_d.rdata[xsr_pkg::DUPLEX_BIT] = i_link.full_duplex;
        s_d.rdata[xsr_pkg::PAUSE_BIT] = i_link.pause_on;
        s_d.rdata[xsr_pkg::EVT_MSB:0] = s_q.evt;
      end else if (i_addr == xsr_pkg::IRQ_ENABLE_OFS) begin
        s_d.rdata[xsr_pkg::EVT_MSB:0] = s_q.irq_en;
      end else if (i_addr == xsr_pkg::TX100_CTRL_OFS) begin
        ctrl_word[xsr_pkg::ERR_COUNT_OFF_BIT] = !s_q.err_count_run;
        ctrl_word[xsr_pkg::AN_DONE_MIRROR_BIT] = i_autoneg_done;
        ctrl_word[xsr_pkg::RX_VPP_BIT] = s_q.ctrl.rx_vpp_high;
        ctrl_word[xsr_pkg::REMOTE_LOOP_BIT] = s_q.ctrl.remote_loop_en;
        ctrl_word[xsr_pkg::BASELINE_BIT] = s_q.ctrl.baseline_restore_en;
        ctrl_word[xsr_pkg::NRZI_BIT] = s_q.ctrl.line_inversion_code_en;
        ctrl_word[xsr_pkg::TX_ISOLATE_BIT] = s_q.ctrl.tx_isolate;
        ctrl_word[xsr_pkg::OP_STATE_LSB +: 3] = i_link.op_state;
        ctrl_word[xsr_pkg::MLT3_BYPASS_BIT] = s_q.ctrl.three_level_code_bypass;
        ctrl_word[xsr_pkg::SCRAMBLER_BYPASS_BIT] = s_q.ctrl.scrambler_bypass;
        s_d.rdata = ctrl_word;
      end
    end
    // Writes to read-only bits are ignored; unmapped writes do nothing.
    if (i_wr) begin
      if (i_addr == xsr_pkg::MODE_CTRL_OFS) begin
        s_d.ctrl.long_reach_squelch = i_wdata[xsr_pkg::LONG_REACH_BIT];
      end else if (i_addr == xsr_pkg::IRQ_ENABLE_OFS) begin
        s_d.irq_en = i_wdata[xsr_pkg::EVT_MSB:0];
      end else if (i_addr == xsr_pkg::TX100_CTRL_OFS) begin
        s_d.err_count_run = !i_wdata[xsr_pkg::ERR_COUNT_OFF_BIT];
        s_d.ctrl.rx_vpp_high = i_wdata[xsr_pkg::RX_VPP_BIT];
        // Remote loopback is only valid with the MAC loopback field at 00; software owns that check.
        s_d.ctrl.remote_loop_en = i_wdata[xsr_pkg::REMOTE_LOOP_BIT];
        s_d.ctrl.baseline_restore_en = i_wdata[xsr_pkg::BASELINE_BIT];
        s_d.ctrl.line_inversion_code_en = i_wdata[xsr_pkg::NRZI_BIT];
        s_d.ctrl.tx_isolate = i_wdata[xsr_pkg::TX_ISOLATE_BIT];
        s_d.ctrl.three_level_code_bypass = i_wdata[xsr_pkg::MLT3_BYPASS_BIT];
        s_d.ctrl.scrambler_bypass = i_wdata[xsr_pkg::SCRAMBLER_BYPASS_BIT];
      end
    end
    // Latch-high events: a set in the clearing cycle wins so no event is lost.
    evt_next = status_rd ? 7'h00 : s_q.evt;
    s_d.evt = evt_next | evt_set;
    s_d.irq = |(s_d.evt & s_d.irq_en);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s_q.rdata <= xsr_pkg::ZERO16;
      s_q.irq <= 1'b0;
      s_q.err_count_run <= 1'b1;
      s_q.ctrl <= xsr_pkg::CTRL_RST;
      s_q.evt <= '0;
      s_q.irq_en <= xsr_pkg::EVT_ENABLE_RST;
      s_q.err_cnt <= '0;
      s_q.link_up_prev <= 1'b0;
      s_q.link_down_seen <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_rdata = s_q.rdata;
  assign o_ctrl = s_q.ctrl;
  assign o_err_count_run = s_q.err_count_run;
  assign o_irq = s_q.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_READ_CLEARS: assert property (@(posedge i_clk) disable iff (!i_rstn)
    status_rd && !i_autoneg_done ##1 !i_autoneg_done |-> !s_q.evt[6])
    else $error("Completion flag survived a status read.");
  AST_FAR_FAULT_LATCH: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_far_fault |=> s_q.evt[5])
    else $error("Remote fault not latched.");
  AST_LINK_DOWN: assert property (@(posedge i_clk) disable iff (!i_rstn)
    s_q.link_up_prev && !i_link_up |=> s_q.evt[4])
    else $error("Link drop not latched.");
  AST_HOLD: assert property (@(posedge i_clk) disable iff (!i_rstn)
    s_q.evt[3] && !status_rd |=> s_q.evt[3])
    else $error("Acknowledge flag dropped without a read.");
  AST_ERR_FULL: assert property (@(posedge i_clk) disable iff (!i_rstn)
    s_q.err_cnt == 7'h3F && i_rx_error && s_q.err_count_run |=> s_q.evt[0])
    else $error("Error full flag missing after 64 errors.");
  AST_FULL_ONLY_AT_MARK: assert property (@(posedge i_clk) disable iff (!i_rstn)
    s_q.evt[0] |-> s_q.err_cnt == xsr_pkg::RX_ERR_FULL_COUNT)
    else $error("Error full flag set below the mark.");
  AST_CNT_MAX: assert property (@(posedge i_clk) disable iff (!i_rstn)
    s_q.err_cnt <= xsr_pkg::RX_ERR_FULL_COUNT)
    else $error("Error counter passed the full mark.");
  AST_FULL_HOLD: assert property (@(posedge i_clk) disable iff (!i_rstn)
    s_q.evt[0] && !status_rd |=> s_q.evt[0])
    else $error("Error full flag dropped without a read.");
  AST_CNT_STEP: assert property (@(posedge i_clk) disable iff (!i_rstn)
    s_q.err_count_run && i_rx_error && !err_full && !status_rd |=> s_q.err_cnt == $past(s_q.err_cnt) + 7'h01)
    else $error("Error counter did not advance.");
  AST_COUNT_OFF_WR: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_wr && i_addr == xsr_pkg::TX100_CTRL_OFS |=> o_err_count_run == !$past(i_wdata[xsr_pkg::ERR_COUNT_OFF_BIT]))
    else $error("Error counter disable not written.");

  // ----------------------------------------------------------------
  // Event latching checks
  // ----------------------------------------------------------------
  AST_DONE_LATCH: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_autoneg_done |=> s_q.evt[6])
    else $error("Completion not latched.");
  AST_DONE_HOLD: assert property (@(posedge i_clk) disable iff (!i_rstn)
    s_q.evt[6] && !status_rd |=> s_q.evt[6])
    else $error("Completion flag dropped without a read.");
  AST_FAR_HOLD: assert property (@(posedge i_clk) disable iff (!i_rstn)
    s_q.evt[5] && !status_rd |=> s_q.evt[5])
    else $error("Remote fault flag dropped without a read.");
  AST_LINK_HOLD: assert property (@(posedge i_clk) disable iff (!i_rstn)
    s_q.evt[4] && !status_rd |=> s_q.evt[4])
    else $error("Link drop flag dropped without a read.");
  AST_LINK_SEEN: assert property (@(posedge i_clk) disable iff (!i_rstn)
    s_q.link_down_seen |-> s_q.evt[4])
    else $error("Link drop seen but not flagged.");
  AST_ACK_LATCH: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_autoneg_ack |=> s_q.evt[3])
    else $error("Acknowledge not latched.");
  AST_PDF_LATCH: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_parallel_fault |=> s_q.evt[2])
    else $error("Parallel detection fault not latched.");
  AST_PDF_HOLD: assert property (@(posedge i_clk) disable iff (!i_rstn)
    s_q.evt[2] && !status_rd |=> s_q.evt[2])
    else $error("Parallel fault flag dropped without a read.");
  AST_PAGE_LATCH: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_autoneg_page |=> s_q.evt[1])
    else $error("Page reception not latched.");
  AST_PAGE_HOLD: assert property (@(posedge i_clk) disable iff (!i_rstn)
    s_q.evt[1] && !status_rd |=> s_q.evt[1])
    else $error("Page flag dropped without a read.");

  // ----------------------------------------------------------------
  // Register access checks
  // ----------------------------------------------------------------
  AST_LONG_REACH_WR: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_wr && i_addr == xsr_pkg::MODE_CTRL_OFS |=> o_ctrl.long_reach_squelch == $past(i_wdata[xsr_pkg::LONG_REACH_BIT]))
    else $error("Squelch mode not written.");
  AST_LONG_REACH_HOLD: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !(i_wr && i_addr == xsr_pkg::MODE_CTRL_OFS) |=> $stable(o_ctrl.long_reach_squelch))
    else $error("Squelch mode changed without a write.");
  AST_DUPLEX_RD: assert property (@(posedge i_clk) disable iff (!i_rstn)
    status_rd |=> o_rdata[xsr_pkg::DUPLEX_BIT] == $past(i_link.full_duplex))
    else $error("Duplex bit misreported.");
  AST_PAUSE_RD: assert property (@(posedge i_clk) disable iff (!i_rstn)
    status_rd |=> o_rdata[xsr_pkg::PAUSE_BIT] == $past(i_link.pause_on))
    else $error("Pause bit misreported.");
  AST_STATUS_RSV: assert property (@(posedge i_clk) disable iff (!i_rstn)
    status_rd |=> o_rdata[15:10] == 6'h00)
    else $error("Reserved status bits not zero.");
  AST_EN_WR: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_wr && i_addr == xsr_pkg::IRQ_ENABLE_OFS |=> s_q.irq_en == $past(i_wdata[xsr_pkg::EVT_MSB:0]))
    else $error("Interrupt enables not written.");
  AST_EN_RD: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_rd && i_addr == xsr_pkg::IRQ_ENABLE_OFS |=> o_rdata == {9'h000, $past(s_q.irq_en)})
    else $error("Interrupt enables misreported.");
  AST_MIRROR: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_rd && i_addr == xsr_pkg::TX100_CTRL_OFS |=> o_rdata[xsr_pkg::AN_DONE_MIRROR_BIT] == $past(i_autoneg_done))
    else $error("Completion mirror misreported.");
  AST_OPSTATE_RD: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_rd && i_addr == xsr_pkg::TX100_CTRL_OFS |=> o_rdata[4:2] == $past(i_link.op_state))
    else $error("Operating mode misreported.");
  AST_NRZI_WR: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_wr && i_addr == xsr_pkg::TX100_CTRL_OFS |=> o_ctrl.line_inversion_code_en == $past(i_wdata[xsr_pkg::NRZI_BIT]))
    else $error("Line code conversion control not written.");
  AST_ISOLATE_WR: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_wr && i_addr == xsr_pkg::TX100_CTRL_OFS |=> o_ctrl.tx_isolate == $past(i_wdata[xsr_pkg::TX_ISOLATE_BIT]))
    else $error("Transmit isolation not written.");
  AST_MLT3_WR: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_wr && i_addr == xsr_pkg::TX100_CTRL_OFS
    |=> o_ctrl.three_level_code_bypass == $past(i_wdata[xsr_pkg::MLT3_BYPASS_BIT]))
    else $error("Three level bypass not written.");
  AST_SCRAMBLER_WR: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_wr && i_addr == xsr_pkg::TX100_CTRL_OFS |=> o_ctrl.scrambler_bypass == $past(i_wdata[xsr_pkg::SCRAMBLER_BYPASS_BIT]))
    else $error("Scrambler bypass not written.");
  AST_RD_IDLE: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !i_rd |=> o_rdata == xsr_pkg::ZERO16)
    else $error("Read data shown outside a read.");
  AST_COUNT_OFF: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !s_q.err_count_run && !status_rd |=> $stable(s_q.err_cnt))
    else $error("Error counter moved while disabled.");
  AST_IRQ: assert property (@(posedge i_clk) disable iff (!i_rstn)
    o_irq == |(s_q.evt & s_q.irq_en))
    else $error("Interrupt does not match enabled events.");
  AST_WRITE_CTRL: assert property (@(posedge i_clk) disable iff (!i_rstn)
    i_wr && i_addr == xsr_pkg::TX100_CTRL_OFS |=> o_ctrl.baseline_restore_en == $past(i_wdata[xsr_pkg::BASELINE_BIT]))
    else $error("DC restoration control not written.");
  AST_SPEED_RD: assert property (@(posedge i_clk) disable iff (!i_rstn)
    status_rd |=> o_rdata[xsr_pkg::SPEED_BIT] == $past(i_link.speed_100))
    else $error("Speed bit misreported.");
endmodule

// ===== tb_xsr_regs.sv
// Self-checking testbench of the transceiver register set.
`timescale 1ns/1ps
module tb_xsr_regs;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [15:0] i_wdata = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [15:0] o_rdata;
  xsr_pkg::xsr_link_type i_link = '0;
  logic i_link_up = 1'b1;
  // Event sources in status bit order; bit 4 is unused because link loss comes from i_link_up.
  logic [6:0] src = 7'h00;
  xsr_pkg::xsr_ctrl_type o_ctrl;
  logic o_err_count_run;
  logic o_irq;
  int num_errors = 0;
  int checks = 0;

  always #2 i_clk = ~i_clk;

  xsr_regs xsr_regs_inst (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_link(i_link), .i_link_up(i_link_up), .i_autoneg_done(src[6]),
    .i_far_fault(src[5]), .i_autoneg_ack(src[3]), .i_parallel_fault(src[2]), .i_autoneg_page(src[1]),
    .i_rx_error(src[0]), .o_ctrl(o_ctrl), .o_err_count_run(o_err_count_run), .o_irq(o_irq));

  // ----------------------------------------
  // Bus and comparison helpers
  // ----------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken just after that edge.
  task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, exp);
  endtask

  task automatic pulse(input int b);
    @(posedge i_clk);
    if (b == 4) i_link_up <= 1'b0;
    else src[b] <= 1'b1;
    @(posedge i_clk);
    i_link_up <= 1'b1;
    src[b] <= 1'b0;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    rdchk(xsr_pkg::MODE_CTRL_OFS, 16'h0000);
    rdchk(xsr_pkg::CFG_STATUS_OFS, 16'h0000);
    rdchk(xsr_pkg::IRQ_ENABLE_OFS, 16'h0000);
    rdchk(xsr_pkg::TX100_CTRL_OFS, 16'h0180);
    rdchk(8'h00, 16'h0000);
    chk(o_ctrl, 16'h0018);
    chk(o_err_count_run, 1'b1);
    chk(o_irq, 1'b0);
    $display("test reset done");
  endtask

  task automatic t_ctrl();
    wr(xsr_pkg::MODE_CTRL_OFS, 16'hFFFF);
    rdchk(xsr_pkg::MODE_CTRL_OFS, 16'h0800);
    chk(o_ctrl.long_reach_squelch, 1'b1);
    @(posedge i_clk);
    i_link.op_state <= 3'h6;
    // The bench models a MAC whose loopback field is 00, so remote loopback may be set.
    wr(xsr_pkg::TX100_CTRL_OFS, 16'hFFFF);
    rdchk(xsr_pkg::TX100_CTRL_OFS, 16'h2BBB);
    chk(o_ctrl, 16'h00FF);
    chk(o_err_count_run, 1'b0);
    wr(xsr_pkg::TX100_CTRL_OFS, 16'h0000);
    rdchk(xsr_pkg::TX100_CTRL_OFS, 16'h0018);
    chk(o_ctrl, 16'h0080);
    wr(xsr_pkg::CFG_STATUS_OFS, 16'hFFFF);
    rdchk(xsr_pkg::CFG_STATUS_OFS, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      @(posedge i_clk);
      i_link.op_state <= 3'(i);
      rdchk(xsr_pkg::TX100_CTRL_OFS, 16'(i << 2));
    end
    @(posedge i_clk);
    i_link <= '{1'b1, 1'b1, 1'b1, 3'h0};
    rdchk(xsr_pkg::CFG_STATUS_OFS, 16'h0380);
    @(posedge i_clk);
    i_link <= '{1'b1, 1'b0, 1'b0, 3'h0};
    rdchk(xsr_pkg::CFG_STATUS_OFS, 16'h0200);
    @(posedge i_clk);
    i_link <= '0;
    $display("test controls done");
  endtask

  task automatic t_events();
    @(posedge i_clk);
    src[6] <= 1'b1;
    // DC restoration and line coding were written off in the control test.
    rdchk(xsr_pkg::TX100_CTRL_OFS, 16'h1000);
    @(posedge i_clk);
    src[6] <= 1'b0;
    rdchk(xsr_pkg::CFG_STATUS_OFS, 16'h0040);
    for (int b = 6; b >= 1; b--) begin
      wr(xsr_pkg::IRQ_ENABLE_OFS, 16'h007F ^ (16'h0001 << b));
      pulse(b);
      repeat (3) @(posedge i_clk);
      #1 chk(o_irq, 1'b0);
      wr(xsr_pkg::IRQ_ENABLE_OFS, 16'h0001 << b);
      rdchk(xsr_pkg::IRQ_ENABLE_OFS, 16'h0001 << b);
      chk(o_irq, 1'b1);
      rdchk(xsr_pkg::CFG_STATUS_OFS, 16'h0001 << b);
      chk(o_irq, 1'b0);
      rdchk(xsr_pkg::CFG_STATUS_OFS, 16'h0000);
    end
    $display("test events done");
  endtask

  task automatic t_rxerr();
    wr(xsr_pkg::IRQ_ENABLE_OFS, 16'h0001);
    wr(xsr_pkg::TX100_CTRL_OFS, 16'h2000);
    repeat (70) pulse(0);
    rdchk(xsr_pkg::CFG_STATUS_OFS, 16'h0000);
    wr(xsr_pkg::TX100_CTRL_OFS, 16'h0000);
    repeat (63) pulse(0);
    rdchk(xsr_pkg::CFG_STATUS_OFS, 16'h0000);
    chk(o_irq, 1'b0);
    pulse(0);
    repeat (2) @(posedge i_clk);
    #1 chk(o_irq, 1'b1);
    rdchk(xsr_pkg::CFG_STATUS_OFS, 16'h0001);
    rdchk(xsr_pkg::CFG_STATUS_OFS, 16'h0000);
    chk(o_irq, 1'b0);
    $display("test error counter done");
  endtask

  // ----------------------------------------
  // Sequence, watchdog and verdict
  // ----------------------------------------
  task automatic summarize();
    $display("checks %0d, mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge i_clk);
    i_rstn <= 1'b1;
    t_reset();
    t_ctrl();
    t_events();
    t_rxerr();
    summarize();
  end

  // The whole run needs under 2000 cycles, so 50 us leaves a wide margin.
  initial begin
    #50000;
    num_errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    summarize();
  end
endmodule
